// [rtl/pdc_regs.sv]
// Purpose: pll divider and loop configuration registers
// Assumes: serial control port presents decoded byte accesses,
//          one access per cycle, synchronous to CLOCK;
//          reset is synchronous and active high
// Notes:   reads answer one cycle after the strobe; unmapped
//          addresses read zero and ignore writes; multi-byte
//          values are not shadowed across their byte writes

`timescale 1ns/100ps

module pdc_regs (
   input  wire logic                          CLOCK,
   input  wire logic                          SYS_RST,
   input  wire logic [pdc_pkg::ADDR_W-1:0]    REG_ADDR,
   input  wire logic                          REG_WR,
   input  wire logic                          REG_RD,
   input  wire logic [pdc_pkg::DATA_W-1:0]    REG_WDATA,
   output logic      [pdc_pkg::DATA_W-1:0]    REG_RDATA,
   output logic                               REG_RVALID,
   output logic      [pdc_pkg::PD_W-1:0]      PLL_PD_MODE,
   output logic                               PLL_RUN,
   output logic      [pdc_pkg::REF_W-1:0]     REF_DIV,
   output logic                               REF_DIV_RST,
   output logic      [pdc_pkg::SWALLOW_W-1:0] SWALLOW_CNT,
   output logic      [pdc_pkg::MAIN_W-1:0]    MAIN_CNT,
   output logic                               PUMP_MIDSUPPLY
);
   import pdc_pkg::*;

   // true when the port addresses the given offset
   // one comparator per offset keeps the decode in a single place
   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] off);
      hit = (addr == off);
   endfunction

   // unused bit positions are not stored at all, so they cannot
   // be written and always read back as zero
   // stored fields
   logic [PD_W-1:0]      pd_r;               // power-down field
   logic [PD_W-1:0]      pd_nxt;             // its next value
   logic [DATA_W-1:0]    ref_lo_r;           // reference low byte
   logic [REF_HI_W-1:0]  ref_hi_r;           // reference upper bits
   logic [SWALLOW_W-1:0] swallow_r;          // swallow counter
   logic [DATA_W-1:0]    main_lo_r;          // main counter low byte
   logic [MAIN_HI_W-1:0] main_hi_r;          // main counter upper bits
   logic                 pump_mid_r;         // pump parked
   logic                 ref_rst_r;          // reference held in reset
   logic                 run_r;              // loop allowed to run
   logic [DATA_W-1:0]    rdata_r;            // read answer
   logic [DATA_W-1:0]    rdata_nxt;          // read answer next
   logic                 rvalid_r;           // read answer strobe

   // next power-down field; only the low two bits are stored
   always_comb begin
      pd_nxt = pd_r;
      if (REG_WR && hit(REG_ADDR, OFF_LOOP_PWR)) begin
         pd_nxt = REG_WDATA[PD_W-1:0];
      end
   end

   // power-down field and the derived run flag, kept in step
   // codes 10 and 11 are stored as written; only 00 runs the loop
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         pd_r  <= RST_PD;
         run_r <= 1'b0;
      end else begin
         pd_r  <= pd_nxt;
         // only the normal code lets the loop run
         run_r <= (pd_nxt == PD_NORMAL);
      end
   end

   // reference divider bytes
   // the 14-bit value is split over two byte registers
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         ref_lo_r <= RST_REF_LOW;
         ref_hi_r <= RST_REF_HI;
      end else if (REG_WR) begin
         if (hit(REG_ADDR, OFF_REF_LOW)) begin
            ref_lo_r <= REG_WDATA;
         end
         if (hit(REG_ADDR, OFF_REF_HIGH)) begin
            // bits 7:6 are dropped
            ref_hi_r <= REG_WDATA[REF_HI_W-1:0];
         end
      end
   end

   // feedback divider counters
   // swallow and main counters together set the feedback ratio
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         swallow_r <= RST_SWALLOW;
         main_lo_r <= RST_MAIN_LO;
         main_hi_r <= RST_MAIN_HI;
      end else if (REG_WR) begin
         if (hit(REG_ADDR, OFF_SWALLOW)) begin
            swallow_r <= REG_WDATA[SWALLOW_W-1:0];
         end
         if (hit(REG_ADDR, OFF_MAIN_LOW)) begin
            main_lo_r <= REG_WDATA;
         end
         if (hit(REG_ADDR, OFF_MAIN_HIGH)) begin
            main_hi_r <= REG_WDATA[MAIN_HI_W-1:0];
         end
      end
   end

   // pump park and reference hold controls; other bits ignored
   // both bits sit in one register, so one write moves them together
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         pump_mid_r <= 1'b0;
         ref_rst_r  <= 1'b0;
      end else if (REG_WR && hit(REG_ADDR, OFF_PUMP_CTL)) begin
         pump_mid_r <= REG_WDATA[POS_PUMP_MID];
         ref_rst_r  <= REG_WDATA[POS_REF_RST];
      end
   end

   // read mux; unused positions and unmapped offsets give zero
   // a read and a write in one cycle return the old byte, since the
   // mux looks at the stored fields and not at the write data
   always_comb begin
      rdata_nxt = '0;
      if (hit(REG_ADDR, OFF_LOOP_PWR)) begin
         rdata_nxt[PD_W-1:0] = pd_r;
      end else if (hit(REG_ADDR, OFF_REF_LOW)) begin
         rdata_nxt = ref_lo_r;
      end else if (hit(REG_ADDR, OFF_REF_HIGH)) begin
         rdata_nxt[REF_HI_W-1:0] = ref_hi_r;
      end else if (hit(REG_ADDR, OFF_SWALLOW)) begin
         rdata_nxt[SWALLOW_W-1:0] = swallow_r;
      end else if (hit(REG_ADDR, OFF_MAIN_LOW)) begin
         rdata_nxt = main_lo_r;
      end else if (hit(REG_ADDR, OFF_MAIN_HIGH)) begin
         rdata_nxt[MAIN_HI_W-1:0] = main_hi_r;
      end else if (hit(REG_ADDR, OFF_PUMP_CTL)) begin
         rdata_nxt[POS_PUMP_MID] = pump_mid_r;
         rdata_nxt[POS_REF_RST]  = ref_rst_r;
      end
   end

   // read answer: registered so the port sees a clean byte
   // rvalid follows every read strobe, mapped or not, so software
   // always gets an answer
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         rdata_r  <= '0;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= REG_RD;
         // data holds between reads, which eases a slow serializer
         if (REG_RD) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   // outputs straight from flip-flops
   // a multi-byte value shows a mixed value between its two byte
   // writes, so write both bytes before relying on it
   assign REG_RDATA      = rdata_r;
   assign REG_RVALID     = rvalid_r;
   assign PLL_PD_MODE    = pd_r;
   assign PLL_RUN        = run_r;
   assign REF_DIV        = {ref_hi_r, ref_lo_r};
   assign REF_DIV_RST    = ref_rst_r;
   assign SWALLOW_CNT    = swallow_r;
   assign MAIN_CNT       = {main_hi_r, main_lo_r};
   assign PUMP_MIDSUPPLY = pump_mid_r;

   // checks on the register behaviour; all are off while SYS_RST is
   // high, so the first attempt after a reset starts on the release edge
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);

   // reset values, seen on the first edge after release
   a_reset_defaults: assert property (
      $past(SYS_RST) |-> (PLL_PD_MODE == RST_PD) && !PLL_RUN)
      else $error("power-down field not at default after reset");

   a_run_follows_mode: assert property (
      ##1 (PLL_RUN == (PLL_PD_MODE == PD_NORMAL)))
      else $error("run flag disagrees with power-down field");

   // write paths: each byte lands on the edge that takes it
   a_pd_field_write: assert property (
      REG_WR && REG_ADDR == OFF_LOOP_PWR
      |=> PLL_PD_MODE == $past(REG_WDATA[PD_W-1:0]))
      else $error("power-down field not written");

   a_ref_high_write: assert property (
      REG_WR && REG_ADDR == OFF_REF_HIGH
      |=> REF_DIV[REF_W-1:DATA_W] == $past(REG_WDATA[REF_HI_W-1:0]))
      else $error("reference upper bits not written");

   a_ref_low_write: assert property (
      REG_WR && REG_ADDR == OFF_REF_LOW
      |=> REF_DIV[DATA_W-1:0] == $past(REG_WDATA) && $stable(SWALLOW_CNT))
      else $error("reference low byte not written");

   a_ref_reset_one: assert property (
      $past(SYS_RST) |-> REF_DIV == {RST_REF_HI, RST_REF_LOW})
      else $error("reference divider not one after reset");

   a_swallow_reset: assert property (
      $past(SYS_RST) |-> SWALLOW_CNT == RST_SWALLOW)
      else $error("swallow counter not zero after reset");

   a_swallow_write: assert property (
      REG_WR && REG_ADDR == OFF_SWALLOW
      |=> SWALLOW_CNT == $past(REG_WDATA[SWALLOW_W-1:0]))
      else $error("swallow counter not written");

   a_main_low_reset: assert property (
      $past(SYS_RST) |-> MAIN_CNT == {RST_MAIN_HI, RST_MAIN_LO})
      else $error("main counter not three after reset");

   a_main_low_write: assert property (
      REG_WR && REG_ADDR == OFF_MAIN_LOW
      |=> MAIN_CNT[DATA_W-1:0] == $past(REG_WDATA)
          && MAIN_CNT[MAIN_W-1:DATA_W] == $past(MAIN_CNT[MAIN_W-1:DATA_W]))
      else $error("main counter low byte not written");

   a_main_high_write: assert property (
      REG_WR && REG_ADDR == OFF_MAIN_HIGH
      |=> MAIN_CNT[MAIN_W-1:DATA_W] == $past(REG_WDATA[MAIN_HI_W-1:0])
          && MAIN_CNT[DATA_W-1:0] == $past(MAIN_CNT[DATA_W-1:0]))
      else $error("main counter upper bits wrong");

   a_pump_park_bit: assert property (
      REG_WR && REG_ADDR == OFF_PUMP_CTL
      |=> PUMP_MIDSUPPLY == $past(REG_WDATA[POS_PUMP_MID]))
      else $error("pump park bit not written");

   a_control_reset: assert property (
      $past(SYS_RST) |-> !PUMP_MIDSUPPLY && !REF_DIV_RST)
      else $error("pump or hold bit set after reset");

   a_ref_hold_write: assert property (
      REG_WR && REG_ADDR == OFF_PUMP_CTL
      |=> REF_DIV_RST == $past(REG_WDATA[POS_REF_RST]))
      else $error("reference hold bit not written");

   a_ref_hold_bit: assert property (
      !(REG_WR && REG_ADDR == OFF_PUMP_CTL)
      |=> $stable(REF_DIV_RST) && $stable(PUMP_MIDSUPPLY))
      else $error("control bits changed without a write");

   a_unmapped_write: assert property (
      REG_WR && (REG_ADDR < OFF_LOOP_PWR || REG_ADDR > OFF_PUMP_CTL)
      |=> $stable(REF_DIV) && $stable(MAIN_CNT) && $stable(SWALLOW_CNT)
          && $stable(PLL_PD_MODE) && $stable(REF_DIV_RST))
      else $error("unmapped write changed a field");

   // read paths: answer one cycle after the strobe, unused bits zero
   a_unused_zero: assert property (
      REG_RD && (REG_ADDR == OFF_REF_HIGH || REG_ADDR == OFF_SWALLOW)
      |=> REG_RVALID && REG_RDATA[DATA_W-1:REF_HI_W] == 2'h0)
      else $error("unused bits read as nonzero");

   a_unused_main_high: assert property (
      REG_RD && (REG_ADDR == OFF_MAIN_HIGH || REG_ADDR == OFF_LOOP_PWR)
      |=> REG_RDATA[DATA_W-1:MAIN_HI_W] == 3'h0)
      else $error("unused high bits read as nonzero");

   a_unmapped_read: assert property (
      REG_RD && (REG_ADDR < OFF_LOOP_PWR || REG_ADDR > OFF_PUMP_CTL)
      |=> REG_RDATA == 8'h00)
      else $error("unmapped offset read as nonzero");

   a_pump_low_bits: assert property (
      REG_RD && REG_ADDR == OFF_PUMP_CTL
      |=> REG_RDATA[POS_REF_RST-1:0] == 6'h00)
      else $error("pump control low bits read as nonzero");

   a_read_latency: assert property (
      REG_RD ##1 !REG_RD |-> REG_RVALID ##1 !REG_RVALID)
      else $error("read strobe not answered after one cycle");

   a_rvalid_only_read: assert property (
      REG_RVALID |-> $past(REG_RD))
      else $error("read answer without a read strobe");

   a_rdata_hold: assert property (
      !REG_RD |=> $stable(REG_RDATA))
      else $error("read byte changed without a read");

   // main scenarios: loop enabled, both controls set, reads answered
   c_loop_enabled: cover property (
      REG_WR && REG_ADDR == OFF_LOOP_PWR ##1 PLL_RUN);
   c_ref_hold: cover property (REF_DIV_RST && PUMP_MIDSUPPLY);
   c_read_main: cover property (
      REG_RD && REG_ADDR == OFF_MAIN_HIGH ##1 REG_RVALID);
   c_unused_code: cover property (
      REG_WR && REG_ADDR == OFF_LOOP_PWR && REG_WDATA[PD_W-1:0] == PD_UNUSED);
   c_unmapped_read: cover property (
      REG_RD && REG_ADDR > OFF_PUMP_CTL ##1 REG_RVALID);

endmodule

// [rtl/pdc_pkg.sv]
// Purpose: constants for the pll divider configuration registers
// Assumes: byte-wide register port fed by the serial control port
// Notes:   every offset and field, and the power-down and divider reset values, live here

package pdc_pkg;

   // register port widths
   localparam int ADDR_W = 10;               // register address width
   localparam int DATA_W = 8;                // register data width

   // register offsets
   localparam logic [ADDR_W-1:0] OFF_LOOP_PWR  = 10'h010;
   localparam logic [ADDR_W-1:0] OFF_REF_LOW   = 10'h011;
   localparam logic [ADDR_W-1:0] OFF_REF_HIGH  = 10'h012;
   localparam logic [ADDR_W-1:0] OFF_SWALLOW   = 10'h013;
   localparam logic [ADDR_W-1:0] OFF_MAIN_LOW  = 10'h014;
   localparam logic [ADDR_W-1:0] OFF_MAIN_HIGH = 10'h015;
   localparam logic [ADDR_W-1:0] OFF_PUMP_CTL  = 10'h016;

   // field widths
   localparam int PD_W      = 2;             // power-down field
   localparam int REF_W     = 14;            // reference divider
   localparam int REF_HI_W  = 6;             // reference upper part
   localparam int SWALLOW_W = 6;             // swallow counter
   localparam int MAIN_W    = 13;            // main feedback counter
   localparam int MAIN_HI_W = 5;             // main counter upper part

   // control bit positions in the pump and counter control register
   localparam int POS_PUMP_MID = 7;          // park pump at mid-supply
   localparam int POS_REF_RST  = 6;          // hold reference divider

   // power-down codes
   typedef enum logic [PD_W-1:0] {
      PD_NORMAL = 2'h0,                      // loop runs
      PD_ASYNC  = 2'h1,                      // asynchronous power-down
      PD_UNUSED = 2'h2,                      // no defined function
      PD_OTHER  = 2'h3                       // not described here
   } pdc_pd_type;

   // reset values
   localparam logic [PD_W-1:0]      RST_PD      = 2'h1;
   localparam logic [DATA_W-1:0]    RST_REF_LOW = 8'h01;
   localparam logic [REF_HI_W-1:0]  RST_REF_HI  = 6'h00;
   localparam logic [SWALLOW_W-1:0] RST_SWALLOW = 6'h00;
   localparam logic [DATA_W-1:0]    RST_MAIN_LO = 8'h03;
   localparam logic [MAIN_HI_W-1:0] RST_MAIN_HI = 5'h00;

endpackage

// [dv/tb_top.sv]
// Purpose: self-checking bench for the pll divider configuration registers
// Assumes: inputs change on the falling edge; reads answer one cycle later
// Notes:   expected read-back values in the two register loops come from the reset and mask tables below
`timescale 1ns/100ps
module tb_top;
   import pdc_pkg::*;
   logic                 CLOCK;          // 40 MHz bench clock
   logic                 SYS_RST;        // synchronous reset
   logic [ADDR_W-1:0]    REG_ADDR;       // access offset
   logic                 REG_WR;         // write strobe
   logic                 REG_RD;         // read strobe
   logic [DATA_W-1:0]    REG_WDATA;      // write byte
   logic [DATA_W-1:0]    REG_RDATA;      // read byte
   logic                 REG_RVALID;     // read answer pulse
   logic [PD_W-1:0]      PLL_PD_MODE;    // power-down field
   logic                 PLL_RUN;        // loop running
   logic [REF_W-1:0]     REF_DIV;        // reference divider
   logic                 REF_DIV_RST;    // reference divider held
   logic [SWALLOW_W-1:0] SWALLOW_CNT;    // swallow counter
   logic [MAIN_W-1:0]    MAIN_CNT;       // main feedback counter
   logic                 PUMP_MIDSUPPLY; // pump parked at mid-supply
   int                   miscompares;    // mismatches seen
   int                   n_tests;        // comparisons made
   // reset value and writable mask for offsets 0x010 to 0x016
   logic [7:0]           rst_tab [7] = '{8'h01, 8'h01, 8'h00, 8'h00,
                                         8'h03, 8'h00, 8'h00};
   logic [7:0]           msk_tab [7] = '{8'h03, 8'hff, 8'h3f, 8'h3f,
                                         8'hff, 8'h1f, 8'hc0};

   pdc_regs u_pdc_regs (
      .CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
      .PLL_PD_MODE(PLL_PD_MODE), .PLL_RUN(PLL_RUN), .REF_DIV(REF_DIV),
      .REF_DIV_RST(REF_DIV_RST), .SWALLOW_CNT(SWALLOW_CNT),
      .MAIN_CNT(MAIN_CNT), .PUMP_MIDSUPPLY(PUMP_MIDSUPPLY)
   );

   // free-running clock, 25 ns period
   initial begin
      CLOCK = 1'b0;
      forever #12.5 CLOCK = ~CLOCK;
   end

   // compare with four-state equality so an unknown never matches
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle write strobe; fields are visible at the next falling edge
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(negedge CLOCK);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      @(negedge CLOCK);
      REG_WR = 1'b0;
   endtask

   // one-cycle read strobe; answer pulse is checked in the following cycle
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      @(negedge CLOCK);
      REG_ADDR = a;
      REG_RD = 1'b1;
      @(negedge CLOCK);
      REG_RD = 1'b0;
      chk(REG_RVALID, 16'h0001);
      chk(REG_RDATA, exp);
   endtask

   // single place where the run ends
   task automatic test_done;
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // reset state after a mid-run reset as well as at start
   task automatic chk_rst;
      chk(PLL_PD_MODE, RST_PD);
      chk(PLL_RUN, 16'h0000);
      chk(REF_DIV, 16'h0001);
      chk(SWALLOW_CNT, 16'h0000);
      chk(MAIN_CNT, 16'h0003);
      chk({PUMP_MIDSUPPLY, REF_DIV_RST}, 16'h0000);
   endtask

   // main sequence
   initial begin
      REG_ADDR = '0;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_WDATA = '0;
      SYS_RST = 1'b1;
      repeat (6) @(negedge CLOCK);
      SYS_RST = 1'b0;
      chk_rst();
      // every register reads its reset value
      for (int i = 0; i < 7; i++) begin
         rd(10'h010 + i[9:0], rst_tab[i]);
      end
      // all ones written; unused bits must read back zero
      for (int i = 0; i < 7; i++) begin
         wr(10'h010 + i[9:0], 8'hff);
         rd(10'h010 + i[9:0], msk_tab[i]);
      end
      chk(REF_DIV, 16'h3fff);
      chk(SWALLOW_CNT, 16'h003f);
      chk(MAIN_CNT, 16'h1fff);
      chk({PUMP_MIDSUPPLY, REF_DIV_RST}, 16'h0003);
      // each power-down code; only 00 lets the loop run
      for (int c = 0; c < 4; c++) begin
         wr(10'h010, c[7:0]);
         chk(PLL_PD_MODE, c[15:0]);
         chk(PLL_RUN, (c == 0) ? 16'h0001 : 16'h0000);
      end
      // multi-byte values built from their byte fields
      wr(10'h011, 8'ha5);
      wr(10'h012, 8'hea);
      chk(REF_DIV, 16'h2aa5);
      wr(10'h013, 8'he1);
      chk(SWALLOW_CNT, 16'h0021);
      // write and read one offset in one cycle: the read sees the old byte
      @(negedge CLOCK);
      REG_ADDR = 10'h013;
      REG_WDATA = 8'h15;
      {REG_WR, REG_RD} = 2'b11;
      @(negedge CLOCK);
      {REG_WR, REG_RD} = 2'b00;
      chk(REG_RDATA, 16'h0021);
      chk(SWALLOW_CNT, 16'h0015);
      wr(10'h014, 8'h5c);
      wr(10'h015, 8'hf3);
      chk(MAIN_CNT, 16'h135c);
      // pump park and divider hold, one at a time
      wr(10'h016, 8'h80);
      chk({PUMP_MIDSUPPLY, REF_DIV_RST}, 16'h0002);
      wr(10'h016, 8'h40);
      chk({PUMP_MIDSUPPLY, REF_DIV_RST}, 16'h0001);
      // unmapped places ignore writes and read zero
      wr(10'h3ff, 8'hff);
      rd(10'h3ff, 8'h00);
      rd(10'h017, 8'h00);
      chk(REF_DIV, 16'h2aa5);
      chk(MAIN_CNT, 16'h135c);
      chk(PLL_PD_MODE, 16'h0003);
      chk({PUMP_MIDSUPPLY, REF_DIV_RST}, 16'h0001);
      rd(10'h014, 8'h5c);
      // reset in mid-run restores every default
      @(negedge CLOCK);
      SYS_RST = 1'b1;
      repeat (2) @(negedge CLOCK);
      SYS_RST = 1'b0;
      chk_rst();
      rd(10'h011, 8'h01);
      test_done();
   end

   // the sequence needs about 85 cycles; cut a hang well beyond that
   initial begin
      #50000;
      miscompares++;
      test_done();
   end
endmodule
